// ---- bench/dpm_mic_pair.sv ----
// model of two pdm microphones sharing one data line
`timescale 1ns/1ns
module dpm_mic_pair #(
    parameter logic [63:0] LEFT_BITS = 64'h0,
    parameter logic [63:0] RIGHT_BITS = 64'h0
) (
    // clock from the device and board reset
    input wire logic mic_clk,
    input wire logic rst,
    // shared data line
    output logic mic_data
);
    logic [5:0] idx_reg;
    // both mics advance only on the device mic clock
    always_ff @(negedge mic_clk or posedge rst) begin
        if (rst) begin
            idx_reg <= 6'h00;
        end else begin
            idx_reg <= idx_reg + 6'h01;
        end
    end
    // left bit holds through the low half, right through the high half
    assign mic_data = mic_clk ? RIGHT_BITS[idx_reg] : LEFT_BITS[idx_reg];
endmodule : dpm_mic_pair

// ---- bench/dual_pdm_mic_capture_test.sv ----
// self-checking testbench for the dual pdm microphone capture block
`timescale 1ns/1ns
module dual_pdm_mic_capture_test;
    import dpm_pkg::*;
    localparam logic [63:0] LBITS = 64'hffff_0f0f_3c3c_a5a5;
    localparam logic [63:0] RBITS = 64'h0000_1248_8421_0001;
    localparam int WIN = 8000;
    // clock starts high: reset is applied on the first falling edge,
    // before any rising edge can sample unreset state
    logic REF_CLK = 1'b1;
    logic RST = 1'b0;
    logic USB_SOF = 1'b0;
    logic USB_SAMPLE = 1'b0;
    logic MCLK_OUT;
    logic MIC_CLK;
    logic MIC_DATA;
    dpm_bits_s PDM_OUT;
    dpm_pcm_s PCM_OUT;
    int mismatches = 0;
    int check_count = 0;
    logic [31:0] word;
    ////////////////////////////////////////////////////////////////////////
    // master clock looped straight back, as on the board
    dpm_capture i_dpm_capture (
        .REF_CLK(REF_CLK), .RST(RST), .MCLK_IN(MCLK_OUT),
        .MIC_DATA(MIC_DATA), .MCLK_OUT(MCLK_OUT), .MIC_CLK(MIC_CLK),
        .USB_SOF(USB_SOF), .USB_SAMPLE(USB_SAMPLE),
        .PDM_OUT(PDM_OUT), .PCM_OUT(PCM_OUT)
    );
    dpm_mic_pair #(.LEFT_BITS(LBITS), .RIGHT_BITS(RBITS)) i_dpm_mic_pair (
        .mic_clk(MIC_CLK), .rst(RST), .mic_data(MIC_DATA)
    );
    initial begin
        forever #4 REF_CLK = ~REF_CLK;
    end
    ////////////////////////////////////////////////////////////////////////
    task automatic check(input logic [31:0] seen, input logic [31:0] exp);
        check_count++;
        if (seen !== exp) begin
            mismatches++;
            $display("BAD t=%0t seen=%h exp=%h", $time, seen, exp);
        end
    endtask : check
    task automatic tally_and_finish;
        if (mismatches == 0 && check_count > 0) begin
            $display("verification passed");
        end else begin
            $display("verification failed");
        end
        $finish;
    endtask : tally_and_finish
    task automatic step;
        @(posedge REF_CLK);
        #1;
    endtask : step
    task automatic do_reset;
        @(negedge REF_CLK);
        RST = 1'b1;
        repeat (4) @(negedge REF_CLK);
        check({MCLK_OUT, MIC_CLK, PDM_OUT, PCM_OUT}, 32'h0);
        RST = 1'b0;
        word = NCO_WORD_NOM;
    endtask : do_reset
    // two full pcm windows, so the boxcar must restart cleanly
    task automatic test_capture;
        int w;
        for (int n = 0; n < 128; n++) begin
            w = 0;
            do begin
                step();
                w++;
            end while (PDM_OUT.valid !== 1'b1 && w < 200);
            check(PDM_OUT.valid, 1'b1);
            check(PDM_OUT.left, LBITS[n % 64]);
            check(PDM_OUT.right, RBITS[n % 64]);
            step();
            check(PDM_OUT.valid, 1'b0);
            if (n % 64 == 63) begin
                check(PCM_OUT.valid, 1'b1);
                check(PCM_OUT.left, $countones(LBITS));
                check(PCM_OUT.right, $countones(RBITS));
            end
        end
    endtask : test_capture
    task automatic test_ratio;
        int rises;
        int edges;
        logic pm;
        logic pc;
        rises = 0;
        edges = 0;
        pm = MCLK_OUT;
        pc = MIC_CLK;
        while (edges < 3) begin
            step();
            if (MCLK_OUT && !pm) rises++;
            if (MIC_CLK && !pc) begin
                if (edges > 0) check(rises, 32'd8);
                rises = 0;
                edges++;
            end
            pm = MCLK_OUT;
            pc = MIC_CLK;
        end
    endtask : test_ratio
    // start phase unknown, so one extra rise is allowed
    task automatic measure_rate;
        int rises;
        logic pm;
        longint unsigned lo;
        lo = (longint'(WIN) * word) >> 32;
        rises = 0;
        pm = MCLK_OUT;
        repeat (WIN) begin
            step();
            if (MCLK_OUT && !pm) rises++;
            pm = MCLK_OUT;
        end
        check(rises >= lo && rises <= lo + 1, 1'b1);
    endtask : measure_rate
    task automatic send_frames(input int frames, input int samples);
        repeat (frames) begin
            repeat (samples) begin
                @(negedge REF_CLK);
                USB_SAMPLE = 1'b1;
                @(negedge REF_CLK);
                USB_SAMPLE = 1'b0;
            end
            @(negedge REF_CLK);
            USB_SOF = 1'b1;
            @(negedge REF_CLK);
            USB_SOF = 1'b0;
        end
        if (samples > 48) word = word + frames * NCO_STEP;
        if (samples < 48) word = word - frames * NCO_STEP;
    endtask : send_frames
    ////////////////////////////////////////////////////////////////////////
    initial begin
        do_reset();
        test_capture();
        test_ratio();
        measure_rate();
        send_frames(8000, 0);
        measure_rate();
        test_ratio();
        do_reset();
        send_frames(1, 48);
        send_frames(150, 49);
        measure_rate();
        tally_and_finish();
    end
    initial begin
        #800000;
        mismatches++;
        tally_and_finish();
    end
endmodule : dual_pdm_mic_capture_test

// ---- verilog/dpm_capture.sv ----
// dual pdm microphone capture: master clock nco, mic clock, demux, pcm
`timescale 1ns/1ns
module dpm_capture #(
    parameter int unsigned DIV_RATIO = dpm_pkg::MIC_DIV,
    parameter int unsigned DECIM_BITS = dpm_pkg::DECIM
) (
    // clock and reset
    input wire logic REF_CLK,
    input wire logic RST,
    // master clock loop and microphone pins
    input wire logic MCLK_IN,
    input wire logic MIC_DATA,
    output logic MCLK_OUT,
    output logic MIC_CLK,
    // usb rate information
    input wire logic USB_SOF,
    input wire logic USB_SAMPLE,
    // captured streams
    output dpm_pkg::dpm_bits_s PDM_OUT,
    output dpm_pkg::dpm_pcm_s PCM_OUT
);
    import dpm_pkg::*;

    localparam int unsigned HALF = DIV_RATIO / 2;
    localparam int unsigned CW = (HALF > 1) ? $clog2(HALF) : 1;
    localparam logic [CW-1:0] HALF_LAST = CW'(HALF - 1);
    localparam int unsigned BW = $clog2(DECIM_BITS);
    localparam logic [BW-1:0] BIT_LAST = BW'(DECIM_BITS - 1);

    if (DIV_RATIO < 2 || DIV_RATIO % 2 != 0) begin : g_bad_div
        $error("DIV_RATIO must be even and at least 2");
    end
    if (DECIM_BITS != DECIM) begin : g_bad_decim
        $error("DECIM_BITS must match the pcm width in the package");
    end

    ////////////////////////////////////////////////////////////////////
    // master clock nco, steered by the usb sample rate

    logic [31:0] nco_acc_reg;
    logic [31:0] nco_word_reg;
    logic [7:0] frame_cnt_reg;

    always_ff @(posedge REF_CLK or posedge RST) begin
        if (RST) begin
            nco_acc_reg <= 32'h0000_0000;
            MCLK_OUT <= 1'b0;
        end else begin
            nco_acc_reg <= nco_acc_reg + nco_word_reg;
            MCLK_OUT <= nco_acc_reg[31]; // RQ6
        end
    end

    // samples delivered per frame reveal the host rate
    always_ff @(posedge REF_CLK or posedge RST) begin
        if (RST) begin
            frame_cnt_reg <= 8'h00;
        end else if (USB_SOF) begin
            frame_cnt_reg <= USB_SAMPLE ? 8'h01 : 8'h00;
        end else if (USB_SAMPLE && frame_cnt_reg != 8'hff) begin
            frame_cnt_reg <= frame_cnt_reg + 8'h01;
        end
    end

    // integrator only: slow but free of overshoot at frame granularity
    always_ff @(posedge REF_CLK or posedge RST) begin
        if (RST) begin
            nco_word_reg <= NCO_WORD_NOM;
        end else if (USB_SOF && frame_cnt_reg > SAMPLES_PER_FRAME) begin
            nco_word_reg <= nco_word_reg + NCO_STEP; // RQ7
        end else if (USB_SOF && frame_cnt_reg < SAMPLES_PER_FRAME) begin
            nco_word_reg <= nco_word_reg - NCO_STEP; // RQ7
        end
    end

    ////////////////////////////////////////////////////////////////////
    // mic clock divided from the looped-back master clock

    logic mclk_in_reg;
    logic mclk_rise;
    logic [CW-1:0] div_cnt_reg;
    logic mic_edge;

    always_ff @(posedge REF_CLK or posedge RST) begin
        if (RST) begin
            mclk_in_reg <= 1'b0;
        end else begin
            mclk_in_reg <= MCLK_IN;
        end
    end

    assign mclk_rise = MCLK_IN && !mclk_in_reg;
    assign mic_edge = mclk_rise && div_cnt_reg == HALF_LAST;

    // reset holds the divider and capture idle with mic clock low
    always_ff @(posedge REF_CLK or posedge RST) begin // RQ9
        if (RST) begin
            div_cnt_reg <= '0;
            MIC_CLK <= 1'b0;
        end else if (mclk_rise) begin
            div_cnt_reg <= mic_edge ? '0 : div_cnt_reg + CW'(1); // RQ11
            if (mic_edge)
                MIC_CLK <= !MIC_CLK; // RQ1 RQ2
        end
    end

    ////////////////////////////////////////////////////////////////////
    // demux of the shared data line
    // data is taken as the mic clock toggles; the slave microphones
    // have had a full half period to settle their bit by then

    always_ff @(posedge REF_CLK or posedge RST) begin
        if (RST) begin
            PDM_OUT <= '0;
        end else begin
            PDM_OUT.valid <= 1'b0;
            if (mic_edge && !MIC_CLK) begin
                PDM_OUT.left <= MIC_DATA; // RQ3 RQ4
            end
            if (mic_edge && MIC_CLK) begin
                PDM_OUT.right <= MIC_DATA; // RQ3 RQ4
                PDM_OUT.valid <= 1'b1; // RQ12
            end
        end
    end

    ////////////////////////////////////////////////////////////////////
    // pdm to pcm: ones count over a boxcar window per channel
    // a crude first stage; finer filtering is left downstream

    logic [BW-1:0] bit_cnt_reg;
    logic [1:0] ch_bit;

    assign ch_bit = {PDM_OUT.left, PDM_OUT.right};

    always_ff @(posedge REF_CLK or posedge RST) begin
        if (RST) begin
            bit_cnt_reg <= '0;
        end else if (PDM_OUT.valid) begin
            bit_cnt_reg <= bit_cnt_reg + BW'(1);
        end
    end

    for (genvar ch = 0; ch < 2; ch++) begin : g_ch
        logic [PCM_W-1:0] ones_reg;
        logic [PCM_W-1:0] sum_next;
        assign sum_next = ones_reg + PCM_W'(ch_bit[1-ch]);
        always_ff @(posedge REF_CLK or posedge RST) begin
            if (RST) begin
                ones_reg <= '0;
            end else if (PDM_OUT.valid) begin
                if (bit_cnt_reg == BIT_LAST) begin
                    ones_reg <= '0; // RQ10
                end else begin
                    ones_reg <= sum_next;
                end
            end
        end
    end

    // one process owns the whole sample word, so every field is a flop
    always_ff @(posedge REF_CLK or posedge RST) begin
        if (RST) begin
            PCM_OUT <= '0;
        end else begin
            PCM_OUT.valid <= PDM_OUT.valid && bit_cnt_reg == BIT_LAST;
            if (PDM_OUT.valid && bit_cnt_reg == BIT_LAST) begin
                PCM_OUT.left <= g_ch[0].sum_next; // RQ10
                PCM_OUT.right <= g_ch[1].sum_next; // RQ10
            end
        end
    end

    ////////////////////////////////////////////////////////////////////
    // assertions

    default clocking cb_ref @(posedge REF_CLK);
    endclocking

    default disable iff (RST);

    sequence mic_rise_s;
        mic_edge && !MIC_CLK;
    endsequence

    sequence mic_fall_s;
        mic_edge && MIC_CLK;
    endsequence

    mic_clk_toggle_a: assert property ( // RQ1
        mic_edge |=> MIC_CLK != $past(MIC_CLK))
        else $error("mic clock missed its divider edge");

    mic_clk_hold_a: assert property ( // RQ2
        !mic_edge |=> MIC_CLK == $past(MIC_CLK))
        else $error("mic clock moved without a master clock edge");

    div_ratio_a: assert property ( // RQ11
        mic_edge |=> div_cnt_reg == '0)
        else $error("divider did not restart after a mic clock edge");

    div_step_a: assert property ( // RQ11
        mclk_rise && !mic_edge |=> div_cnt_reg == $past(div_cnt_reg) + CW'(1))
        else $error("divider skipped a master clock rise");

    left_capture_a: assert property ( // RQ3
        mic_rise_s |=> PDM_OUT.left == $past(MIC_DATA) && !PDM_OUT.valid)
        else $error("left bit not taken on mic clock rise");

    right_capture_a: assert property ( // RQ3
        mic_fall_s |=> PDM_OUT.right == $past(MIC_DATA) && PDM_OUT.valid)
        else $error("right bit not taken on mic clock fall");

    bit_strobe_a: assert property ( // RQ12
        PDM_OUT.valid |-> $past(mic_edge) && !MIC_CLK)
        else $error("bit strobe outside a mic clock fall");

    pcm_strobe_a: assert property ( // RQ10
        PDM_OUT.valid && bit_cnt_reg == BIT_LAST
        |=> PCM_OUT.valid ##1 !PCM_OUT.valid)
        else $error("pcm sample strobe wrong");

    nco_up_a: assert property ( // RQ7
        USB_SOF && frame_cnt_reg > SAMPLES_PER_FRAME
        |=> nco_word_reg == $past(nco_word_reg) + NCO_STEP)
        else $error("master clock not sped up for a fast host");

    nco_down_a: assert property ( // RQ7
        USB_SOF && frame_cnt_reg < SAMPLES_PER_FRAME
        |=> nco_word_reg == $past(nco_word_reg) - NCO_STEP)
        else $error("master clock not slowed for a slow host");

    // checked while reset is high, so it must not be disabled by it
    reset_idle_a: assert property (disable iff (1'b0) // RQ9
        RST |-> !MIC_CLK && !PDM_OUT.valid && !PCM_OUT.valid)
        else $error("capture active during reset");
endmodule : dpm_capture

// ---- verilog/dpm_pkg.sv ----
// constants and carrier types for the dual pdm microphone capture block
//
// Behaviour
// [RQ1] drive one 3.072MHz mic clock pacing capture
// [RQ2] mic clock divided from looped-back master clock
// [RQ3] rising edge left bit, falling edge right
// [RQ4] microphones configured left rising, right falling
// [RQ5] microphones clocked only by our mic clock
// [RQ6] master clock 24.576MHz, tracks host audio rate
// [RQ7] usb adaptive endpoint steers master clock generation
// [RQ8] system supplies reference clock timing all logic
// [RQ9] reset holds capture logic until released
// [RQ10] convert each pdm stream into pcm samples
// [RQ11] divide master clock by eight, edge aligned
// [RQ12] separate left/right bits, one strobe per period
package dpm_pkg;
    // clock rates in kHz
    localparam int unsigned REF_CLK_KHZ = 125000;
    localparam int unsigned MCLK_NOM_KHZ = 24576;
    localparam int unsigned MIC_CLK_KHZ = 3072;
    localparam int unsigned MIC_DIV = MCLK_NOM_KHZ / MIC_CLK_KHZ;
    // nco tuning word for the nominal master clock, 32-bit phase
    localparam longint unsigned NCO_WORD_L =
        (64'd4294967296 * 64'(MCLK_NOM_KHZ)) / 64'(REF_CLK_KHZ);
    localparam logic [31:0] NCO_WORD_NOM = NCO_WORD_L[31:0];
    localparam logic [31:0] NCO_STEP = 32'h0000_0400;
    // usb frame is 1 ms; samples per frame at 48 kHz
    localparam logic [7:0] SAMPLES_PER_FRAME = 8'h30;
    // pdm bits per pcm sample
    localparam int unsigned DECIM = 64;
    localparam int unsigned PCM_W = $clog2(DECIM) + 1;

    typedef struct packed {
        logic left;
        logic right;
        logic valid;
    } dpm_bits_s;

    typedef struct packed {
        logic [PCM_W-1:0] left;
        logic [PCM_W-1:0] right;
        logic valid;
    } dpm_pcm_s;
endpackage : dpm_pkg
